//--- hw/ppio_top.sv
`timescale 1ns/100ps
`default_nettype none
module ppio_top import ppio_pkg::*; (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] first_byte_port_in,
  output logic [7:0] first_byte_port_out,
  output logic [7:0] first_byte_port_oe,
  input wire logic [7:0] second_byte_port_in,
  output logic [7:0] second_byte_port_out,
  output logic [7:0] second_byte_port_oe,
  input wire logic [7:0] control_nibble_port_in,
  output logic [7:0] control_nibble_port_out,
  output logic [7:0] control_nibble_port_oe,
  input wire logic [1:0] irq_enable_select_jumper,
  output logic irq
);
  // ---------------------------------------------------
  // Declarations
  // ---------------------------------------------------
  // Configuration, latches and registered outputs
  ppio_cfg_t cfg_reg;
  logic [7:0] out_a_reg;
  logic [7:0] out_b_reg;
  logic [7:0] out_c_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;
  // Bus decode
  logic wr_a;
  logic wr_b;
  logic wr_c;
  logic wr_cfg;
  logic mode_set;
  logic bit_cmd;
  logic rd_a;
  logic rd_b;
  // Group mode and path decode
  logic a_hs;
  logic a_bidir;
  logic b_hs;
  logic a_in_path;
  logic a_out_path;
  logic b_in_path;
  logic b_out_path;
  // Handshake channel results
  logic [7:0] a_in_data;
  logic [7:0] b_in_data;
  ppio_hs_t hs_a;
  ppio_hs_t hs_b;
  // Third-port drive and line levels
  logic [7:0] c_out;
  logic [7:0] c_oe;
  logic [7:0] c_level;
  logic [7:0] rd_mux;
  // Interrupt enables and request lines
  logic irq_line_en;
  logic first_group_irq_enable_bit;
  logic second_group_irq_enable_bit;
  logic group_a_request_line;
  logic group_b_request_line;
  logic irq_enable_choice_low;
  logic irq_enable_choice_mid;
  logic irq_enable_choice_high;

  // ---------------------------------------------------
  // Host bus decode
  // ---------------------------------------------------
  // Strobe qualified by one register offset
  function automatic logic reg_hit(input logic strobe, input logic [1:0] addr,
    input logic [1:0] ofs);
    reg_hit = strobe && (addr == ofs);
  endfunction

  // Four byte registers at consecutive offsets
  assign wr_a = reg_hit(reg_wr, reg_addr, OFS_PORT_A);
  assign wr_b = reg_hit(reg_wr, reg_addr, OFS_PORT_B);
  assign wr_c = reg_hit(reg_wr, reg_addr, OFS_PORT_C);
  assign wr_cfg = reg_hit(reg_wr, reg_addr, OFS_CONFIG);
  // Port reads that acknowledge handshake state
  assign rd_a = reg_hit(reg_rd, reg_addr, OFS_PORT_A);
  assign rd_b = reg_hit(reg_rd, reg_addr, OFS_PORT_B);
  // Config MSB splits mode words from bit commands
  assign mode_set = wr_cfg & reg_wdata[CFG_MODE_SET];
  assign bit_cmd = wr_cfg & ~reg_wdata[CFG_MODE_SET];

  // ---------------------------------------------------
  // Configuration word
  // ---------------------------------------------------
  // Mode word loads both group settings at once
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg_reg <= CFG_RESET;
    end else if (mode_set) begin
      cfg_reg <= reg_wdata[CFG_MODE_SET-1:0];
    end
  end

  // Group mode decode
  assign a_hs = (cfg_reg.mode_a != MODE_SIMPLE);
  assign a_bidir = cfg_reg.mode_a[1];
  assign b_hs = cfg_reg.mode_b;
  // Group A and B handshake paths; A bidirectional uses both
  assign a_in_path = a_hs & (a_bidir | cfg_reg.a_in);
  assign a_out_path = a_hs & (a_bidir | ~cfg_reg.a_in);
  assign b_in_path = b_hs & cfg_reg.b_in;
  assign b_out_path = b_hs & ~cfg_reg.b_in;

  // ---------------------------------------------------
  // Output latches
  // ---------------------------------------------------
  // First port latch, cleared by a new mode word
  always_ff @(posedge ref_clk) begin
    if (!rstn || mode_set) begin
      out_a_reg <= BYTE_ZERO;
    end else if (wr_a) begin
      out_a_reg <= reg_wdata;
    end
  end

  // Second port latch
  always_ff @(posedge ref_clk) begin
    if (!rstn || mode_set) begin
      out_b_reg <= BYTE_ZERO;
    end else if (wr_b) begin
      out_b_reg <= reg_wdata;
    end
  end

  // Third port latch, byte write or single-bit command
  always_ff @(posedge ref_clk) begin
    if (!rstn || mode_set) begin
      out_c_reg <= BYTE_ZERO;
    end else if (wr_c) begin
      out_c_reg <= reg_wdata;
    end else if (bit_cmd) begin
      if (reg_wdata[BSR_VAL]) begin
        out_c_reg <= out_c_reg | ppio_bit_mask(reg_wdata[BSR_SEL_LSB +: 3]);
      end else begin
        out_c_reg <= out_c_reg & ~ppio_bit_mask(reg_wdata[BSR_SEL_LSB +: 3]);
      end
    end
  end

  // ---------------------------------------------------
  // Handshake channels
  // ---------------------------------------------------
  // Group A: strobe on bit four, ack on bit six
  ppio_hs_chan #(
    .W(PORT_W)
  ) u_hs_a (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clear(mode_set),
    .in_en(a_in_path),
    .out_en(a_out_path),
    .stb_n(control_nibble_port_in[C_STB_A]),
    .ack_n(control_nibble_port_in[C_ACK_A]),
    .pins_in(first_byte_port_in),
    .host_rd(rd_a),
    .host_wr(wr_a),
    .inte_in(out_c_reg[C_STB_A]),
    .inte_out(out_c_reg[C_ACK_A]),
    .in_data(a_in_data),
    .hs(hs_a)
  );

  // Group B: one line serves as strobe or ack
  ppio_hs_chan #(
    .W(PORT_W)
  ) u_hs_b (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clear(mode_set),
    .in_en(b_in_path),
    .out_en(b_out_path),
    .stb_n(control_nibble_port_in[C_STB_B]),
    .ack_n(control_nibble_port_in[C_STB_B]),
    .pins_in(second_byte_port_in),
    .host_rd(rd_b),
    .host_wr(wr_b),
    .inte_in(out_c_reg[C_STB_B]),
    .inte_out(out_c_reg[C_STB_B]),
    .in_data(b_in_data),
    .hs(hs_b)
  );

  // ---------------------------------------------------
  // Byte port drivers
  // ---------------------------------------------------
  // Bidirectional port drives only while ack is low
  always_comb begin
    // Latch always offered; only the enable changes
    first_byte_port_out = out_a_reg;
    if (a_bidir) begin
      first_byte_port_oe = {8{~control_nibble_port_in[C_ACK_A]}};
    end else if (cfg_reg.a_in) begin
      first_byte_port_oe = BYTE_ZERO;
    end else begin
      first_byte_port_oe = BYTE_ONES;
    end
  end

  // Second port follows its direction bit
  assign second_byte_port_out = out_b_reg;
  assign second_byte_port_oe = cfg_reg.b_in ? BYTE_ZERO : BYTE_ONES;

  // ---------------------------------------------------
  // Third port drivers
  // ---------------------------------------------------
  // Nibble directions, then handshake lines take over
  always_comb begin
    c_out = out_c_reg;
    c_oe = {{4{~cfg_reg.cu_in}}, {4{~cfg_reg.cl_in}}};
    // Group B: request and flag out, strobe or ack in
    if (b_hs) begin
      c_out[C_INTR_B] = hs_b.intr;
      c_oe[C_INTR_B] = 1'b1;
      c_out[C_FLAG_B] = cfg_reg.b_in ? hs_b.ibf : hs_b.obf_n;
      c_oe[C_FLAG_B] = 1'b1;
      c_oe[C_STB_B] = 1'b0;
    end
    // Group A: request out, then lines of each path
    if (a_hs) begin
      c_out[C_INTR_A] = hs_a.intr;
      c_oe[C_INTR_A] = 1'b1;
      // Input side: full flag out, strobe in
      if (a_in_path) begin
        c_out[C_IBF_A] = hs_a.ibf;
        c_oe[C_IBF_A] = 1'b1;
        c_oe[C_STB_A] = 1'b0;
      end
      // Output side: full flag out, ack in
      if (a_out_path) begin
        c_out[C_OBF_A] = hs_a.obf_n;
        c_oe[C_OBF_A] = 1'b1;
        c_oe[C_ACK_A] = 1'b0;
      end
    end
  end

  // Drive values and enables to the pins
  assign control_nibble_port_out = c_out;
  assign control_nibble_port_oe = c_oe;

  // Line level: own drive where enabled, else the pin
  for (genvar i = 0; i < PORT_W; i++) begin : g_c_level
    assign c_level[i] = c_oe[i] ? c_out[i] : control_nibble_port_in[i];
  end

  // ---------------------------------------------------
  // Read path
  // ---------------------------------------------------
  // Port read source by mode and direction
  always_comb begin
    case (reg_addr)
      OFS_PORT_A: begin
        if (a_in_path) begin
          rd_mux = a_in_data;
        end else if (cfg_reg.a_in && !a_hs) begin
          rd_mux = first_byte_port_in;
        end else begin
          rd_mux = out_a_reg;
        end
      end
      OFS_PORT_B: begin
        if (b_in_path) begin
          rd_mux = b_in_data;
        end else if (cfg_reg.b_in) begin
          rd_mux = second_byte_port_in;
        end else begin
          rd_mux = out_b_reg;
        end
      end
      // Each third-port line as driven or as seen
      OFS_PORT_C: begin
        rd_mux = c_level;
      end
      default: begin
        rd_mux = BYTE_ZERO;
      end
    endcase
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata_reg <= BYTE_ZERO;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= BYTE_ZERO;
    end
  end

  // Registered read data to the bus
  assign reg_rdata = rdata_reg;

  // ---------------------------------------------------
  // Interrupt request
  // ---------------------------------------------------
  // Candidate enable lines as seen on the wires
  assign irq_enable_choice_low = c_level[C_STB_B];
  assign irq_enable_choice_mid = c_level[C_STB_A];
  assign irq_enable_choice_high = c_level[C_ACK_A];

  // Jumper picks the active-low enable line
  always_comb begin
    case (irq_enable_select_jumper)
      IRQ_SEL_LOW: irq_line_en = ~irq_enable_choice_low;
      IRQ_SEL_MID: irq_line_en = ~irq_enable_choice_mid;
      IRQ_SEL_HIGH: irq_line_en = ~irq_enable_choice_high;
      default: irq_line_en = 1'b0;
    endcase
  end

  // Software request enables held in third-port latch
  assign first_group_irq_enable_bit = (a_in_path & out_c_reg[C_STB_A])
    | (a_out_path & out_c_reg[C_ACK_A]);
  assign second_group_irq_enable_bit = b_hs & out_c_reg[C_STB_B];

  // Request levels as seen on the wires
  assign group_a_request_line = c_level[C_INTR_A];
  assign group_b_request_line = c_level[C_INTR_B];

  // Request raised by a high request line
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_line_en
        & ((first_group_irq_enable_bit & group_a_request_line)
        | (second_group_irq_enable_bit & group_b_request_line));
    end
  end

  // Registered request to the host
  assign irq = irq_reg;
endmodule
`default_nettype wire

//--- common/ppio_pkg.sv
`default_nettype none
package ppio_pkg;
  // ---------------------------------------------------
  // Register map and widths
  // ---------------------------------------------------
  localparam int PORT_W = 8;
  localparam logic [1:0] OFS_PORT_A = 2'h0;
  localparam logic [1:0] OFS_PORT_B = 2'h1;
  localparam logic [1:0] OFS_PORT_C = 2'h2;
  localparam logic [1:0] OFS_CONFIG = 2'h3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  // ---------------------------------------------------
  // Configuration word fields
  // ---------------------------------------------------
  localparam int CFG_MODE_SET = 7;
  localparam int BSR_SEL_LSB = 1;
  localparam int BSR_VAL = 0;
  localparam logic [1:0] MODE_SIMPLE = 2'h0;
  localparam logic [1:0] MODE_STROBED = 2'h1;
  typedef struct packed {
    logic [1:0] mode_a;
    logic a_in;
    logic cu_in;
    logic mode_b;
    logic b_in;
    logic cl_in;
  } ppio_cfg_t;
  localparam ppio_cfg_t CFG_RESET = 7'h1b;
  // ---------------------------------------------------
  // Third-port handshake bit positions
  // ---------------------------------------------------
  localparam int C_INTR_B = 0;
  localparam int C_FLAG_B = 1;
  localparam int C_STB_B = 2;
  localparam int C_INTR_A = 3;
  localparam int C_STB_A = 4;
  localparam int C_IBF_A = 5;
  localparam int C_ACK_A = 6;
  localparam int C_OBF_A = 7;
  // Interrupt enable jumper codes
  localparam logic [1:0] IRQ_SEL_NONE = 2'h0;
  localparam logic [1:0] IRQ_SEL_LOW = 2'h1;
  localparam logic [1:0] IRQ_SEL_MID = 2'h2;
  localparam logic [1:0] IRQ_SEL_HIGH = 2'h3;
  // Handshake status of one channel
  typedef struct packed {
    logic ibf;
    logic obf_n;
    logic intr;
  } ppio_hs_t;
  // One-hot mask for a bit number
  function automatic logic [7:0] ppio_bit_mask(input logic [2:0] sel);
    ppio_bit_mask = 8'h01 << sel;
  endfunction
endpackage
`default_nettype wire

//--- hw/ppio_hs_chan.sv
`timescale 1ns/100ps
`default_nettype none
module ppio_hs_chan import ppio_pkg::*; #(
  parameter int W = PORT_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic in_en,
  input wire logic out_en,
  input wire logic stb_n,
  input wire logic ack_n,
  input wire logic [W-1:0] pins_in,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic inte_in,
  input wire logic inte_out,
  output logic [W-1:0] in_data,
  output ppio_hs_t hs
);
  // ---------------------------------------------------
  // Checks and edge detection
  // ---------------------------------------------------
  if (W != PORT_W) begin : g_bad_width
    $error("handshake channel width must equal port width");
  end
  logic stb_prev_reg;
  logic ack_prev_reg;
  logic [W-1:0] in_data_reg;
  logic ibf_reg;
  logic obf_n_reg;
  logic intr_in_reg;
  logic intr_out_reg;
  logic stb_fall;
  logic stb_rise;
  logic ack_fall;
  logic ack_rise;
  assign stb_fall = in_en & stb_prev_reg & ~stb_n;
  assign stb_rise = in_en & ~stb_prev_reg & stb_n;
  assign ack_fall = out_en & ack_prev_reg & ~ack_n;
  assign ack_rise = out_en & ~ack_prev_reg & ack_n;
  // Previous strobe levels
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stb_prev_reg <= 1'b1;
      ack_prev_reg <= 1'b1;
    end else begin
      stb_prev_reg <= stb_n;
      ack_prev_reg <= ack_n;
    end
  end
  // ---------------------------------------------------
  // Input path
  // ---------------------------------------------------
  // Data captured at strobe fall
  always_ff @(posedge ref_clk) begin
    if (!rstn || clear) begin
      in_data_reg <= '0;
    end else if (stb_fall) begin
      in_data_reg <= pins_in;
    end
  end
  // Buffer full: strobe sets, host read clears
  always_ff @(posedge ref_clk) begin
    if (!rstn || clear || !in_en) begin
      ibf_reg <= 1'b0;
    end else if (stb_fall) begin
      ibf_reg <= 1'b1;
    end else if (host_rd) begin
      ibf_reg <= 1'b0;
    end
  end
  // Input request at strobe end while full
  always_ff @(posedge ref_clk) begin
    if (!rstn || clear || !inte_in || !in_en) begin
      intr_in_reg <= 1'b0;
    end else if (stb_rise && ibf_reg) begin
      intr_in_reg <= 1'b1;
    end else if (host_rd) begin
      intr_in_reg <= 1'b0;
    end
  end
  // ---------------------------------------------------
  // Output path
  // ---------------------------------------------------
  // Output full (low active): host write sets, ack clears
  always_ff @(posedge ref_clk) begin
    if (!rstn || clear || !out_en) begin
      obf_n_reg <= 1'b1;
    end else if (host_wr) begin
      obf_n_reg <= 1'b0;
    end else if (ack_fall) begin
      obf_n_reg <= 1'b1;
    end
  end
  // Output request at ack end once emptied
  always_ff @(posedge ref_clk) begin
    if (!rstn || clear || !inte_out || !out_en) begin
      intr_out_reg <= 1'b0;
    end else if (ack_rise && obf_n_reg) begin
      intr_out_reg <= 1'b1;
    end else if (host_wr) begin
      intr_out_reg <= 1'b0;
    end
  end
  assign in_data = in_data_reg;
  assign hs.ibf = ibf_reg;
  assign hs.obf_n = obf_n_reg;
  assign hs.intr = intr_in_reg | intr_out_reg;
endmodule
`default_nettype wire

//--- bench/ppio_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ppio_checker import ppio_pkg::*; (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] first_byte_port_in,
  input wire logic [7:0] first_byte_port_out,
  input wire logic [7:0] first_byte_port_oe,
  input wire logic [7:0] second_byte_port_in,
  input wire logic [7:0] second_byte_port_out,
  input wire logic [7:0] second_byte_port_oe,
  input wire logic [7:0] control_nibble_port_in,
  input wire logic [7:0] control_nibble_port_out,
  input wire logic [7:0] control_nibble_port_oe,
  input wire logic [1:0] irq_enable_select_jumper,
  input wire logic irq
);
  // ---------------------------------------------
  // Helper logic
  // ---------------------------------------------
  logic [7:0] cfg_reg;
  logic [7:0] c_lvl;
  logic cfg_wr;
  logic m0;
  logic irq_cause;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Shadow of the last mode word
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg_reg <= 8'h9b;
    end else if (cfg_wr && reg_wdata[7]) begin
      cfg_reg <= reg_wdata;
    end
  end
  // Decodes, third-port wire levels and the jumper-gated request cause
  assign cfg_wr = reg_wr && reg_addr == OFS_CONFIG;
  assign m0 = cfg_reg[6:5] == MODE_SIMPLE && !cfg_reg[2];
  assign c_lvl = (control_nibble_port_oe & control_nibble_port_out) |
                 (~control_nibble_port_oe & control_nibble_port_in);
  assign irq_cause = irq_enable_select_jumper != IRQ_SEL_NONE &&
                     !c_lvl[{irq_enable_select_jumper, 1'b0}] &&
                     (c_lvl[C_INTR_A] || c_lvl[C_INTR_B]);
  // Strobe fall in strobed input mode, then the full flag rises
  sequence s_stb_fall;
    cfg_reg[6:4] == 3'b011 && $fell(control_nibble_port_in[C_STB_A]);
  endsequence
  sequence s_ibf_up;
    ##[1:2] control_nibble_port_out[C_IBF_A];
  endsequence
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == BYTE_ZERO)
    else $error("read data not zero outside read slot");
  AST_CFG_RD: assert property (reg_rd && reg_addr == OFS_CONFIG |=> reg_rdata == BYTE_ZERO)
    else $error("config register readable");
  AST_MODESET_CLR: assert property (cfg_wr && reg_wdata[7] |=>
    first_byte_port_out == BYTE_ZERO && second_byte_port_out == BYTE_ZERO)
    else $error("mode word left a latch set");
  AST_A_WRITE: assert property (reg_wr && reg_addr == OFS_PORT_A && m0 && !cfg_reg[4] |=>
    first_byte_port_out == $past(reg_wdata))
    else $error("port write not latched");
  AST_OE_MODE0: assert property (m0 |-> first_byte_port_oe == {8{!cfg_reg[4]}} &&
    second_byte_port_oe == {8{!cfg_reg[1]}} &&
    control_nibble_port_oe == {{4{!cfg_reg[3]}}, {4{!cfg_reg[0]}}})
    else $error("drive enables disagree with directions");
  AST_BIT_CMD: assert property (cfg_wr && !reg_wdata[7] && m0 |=>
    control_nibble_port_out[$past(reg_wdata[3:1])] == $past(reg_wdata[0]))
    else $error("bit command missed its bit");
  AST_IRQ_CAUSE: assert property (irq |-> $past(irq_cause))
    else $error("request without a cause");
  AST_IRQ_NONE: assert property (irq_enable_select_jumper == IRQ_SEL_NONE |=> !irq)
    else $error("request with jumper open");
  AST_IBF_SET: assert property (s_stb_fall |-> s_ibf_up)
    else $error("strobe did not set full flag");
  AST_IBF_OE: assert property (cfg_reg[6:4] == 3'b011 |->
    control_nibble_port_oe[C_IBF_A] && !control_nibble_port_oe[C_STB_A])
    else $error("handshake line directions wrong");
endmodule
bind ppio_top ppio_checker u_chk (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .first_byte_port_in, .first_byte_port_out, .first_byte_port_oe,
  .second_byte_port_in, .second_byte_port_out, .second_byte_port_oe, .control_nibble_port_in,
  .control_nibble_port_out, .control_nibble_port_oe, .irq_enable_select_jumper, .irq);
`default_nettype wire

//--- bench/ppio_equip.sv
`timescale 1ns/100ps
`default_nettype none
module ppio_equip import ppio_pkg::*; (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] first_byte_port_out,
  input wire logic [7:0] first_byte_port_oe,
  input wire logic [7:0] second_byte_port_out,
  input wire logic [7:0] second_byte_port_oe,
  input wire logic [7:0] control_nibble_port_out,
  input wire logic [7:0] control_nibble_port_oe,
  input wire logic [7:0] drv_a,
  input wire logic [7:0] drv_b,
  input wire logic [7:0] drv_c,
  input wire logic stb_go,
  input wire logic [3:0] stb_len,
  output logic [7:0] first_byte_port_in,
  output logic [7:0] second_byte_port_in,
  output logic [7:0] control_nibble_port_in
);
  logic [3:0] cnt_reg;
  logic [7:0] c_drv;
  // Strobe held low for stb_len cycles while the data stay put
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
    end else if (stb_go) begin
      cnt_reg <= stb_len;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
  // Wire levels: a driving device wins, the equipment drives the rest
  assign c_drv = {drv_c[7:5], cnt_reg == 4'h0, drv_c[3:0]};
  assign first_byte_port_in = (first_byte_port_oe & first_byte_port_out) |
                              (~first_byte_port_oe & drv_a);
  assign second_byte_port_in = (second_byte_port_oe & second_byte_port_out) |
                               (~second_byte_port_oe & drv_b);
  assign control_nibble_port_in = (control_nibble_port_oe & control_nibble_port_out) |
                                  (~control_nibble_port_oe & c_drv);
endmodule
`default_nettype wire

//--- bench/ppio_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module ppio_top_test import ppio_pkg::*;;
  logic ref_clk, rstn, reg_wr, reg_rd, irq, stb_go;
  logic [1:0] reg_addr, irq_enable_select_jumper;
  logic [7:0] reg_wdata, reg_rdata, drv_a, drv_b, drv_c, exp_c;
  logic [7:0] first_byte_port_in, first_byte_port_out, first_byte_port_oe;
  logic [7:0] second_byte_port_in, second_byte_port_out, second_byte_port_oe;
  logic [7:0] control_nibble_port_in, control_nibble_port_out, control_nibble_port_oe;
  logic [3:0] stb_len;
  int n_errors, tests_run, i;
  ppio_top u_dut (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .first_byte_port_in, .first_byte_port_out, .first_byte_port_oe, .second_byte_port_in,
    .second_byte_port_out, .second_byte_port_oe, .control_nibble_port_in,
    .control_nibble_port_out, .control_nibble_port_oe, .irq_enable_select_jumper, .irq);
  ppio_equip u_equip (.ref_clk, .rstn, .first_byte_port_out, .first_byte_port_oe,
    .second_byte_port_out, .second_byte_port_oe, .control_nibble_port_out,
    .control_nibble_port_oe, .drv_a, .drv_b, .drv_c, .stb_go, .stb_len,
    .first_byte_port_in, .second_byte_port_in, .control_nibble_port_in);
  // ---------------------------------------------
  // Bus tasks and comparison
  // ---------------------------------------------
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Read one byte and compare it with the expected value
  task automatic rchk(input string what, input logic [1:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask
  // Strobe from the equipment, then a short settle
  task automatic strobe(input logic [3:0] len);
    @(posedge ref_clk);
    stb_len <= len;
    stb_go <= 1'b1;
    @(posedge ref_clk);
    stb_go <= 1'b0;
    repeat (len + 4) @(posedge ref_clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    end_of_test;
  end
  // ---------------------------------------------
  // Test sequence
  // ---------------------------------------------
  initial begin
    rstn = 1'b0;
    {reg_wr, reg_rd, stb_go, reg_addr, reg_wdata, stb_len} = '0;
    {drv_a, drv_b, drv_c} = {8'h5a, 8'h00, 8'hff};
    irq_enable_select_jumper = IRQ_SEL_NONE;
    n_errors = 0;
    tests_run = 0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    rchk("a live", OFS_PORT_A, 8'h5a);
    @(posedge ref_clk) drv_a <= 8'ha5;
    rchk("a live", OFS_PORT_A, 8'ha5);
    rchk("cfg read", OFS_CONFIG, BYTE_ZERO);
    chk("a oe", BYTE_ZERO, first_byte_port_oe);
    $display("test reset done");
    wr(OFS_CONFIG, 8'h80);
    wr(OFS_PORT_A, 8'h3c);
    wr(OFS_PORT_B, 8'hc3);
    wr(OFS_PORT_C, 8'h96);
    rchk("a latch", OFS_PORT_A, 8'h3c);
    rchk("b latch", OFS_PORT_B, 8'hc3);
    rchk("c latch", OFS_PORT_C, 8'h96);
    chk("b pins", 8'hc3, second_byte_port_in);
    $display("test outputs done");
    wr(OFS_PORT_C, BYTE_ZERO);
    exp_c = BYTE_ZERO;
    for (i = 0; i < 8; i++) begin
      wr(OFS_CONFIG, {4'h0, i[2:0], 1'b1});
      exp_c = exp_c | (8'h01 << i);
      rchk("bit set", OFS_PORT_C, exp_c);
    end
    wr(OFS_CONFIG, 8'h0a);
    rchk("bit clear", OFS_PORT_C, 8'hdf);
    $display("test bit commands done");
    @(posedge ref_clk) {drv_a, drv_c} <= {8'h66, 8'ha5};
    wr(OFS_CONFIG, 8'h91);
    rchk("a mixed", OFS_PORT_A, 8'h66);
    rchk("c mixed", OFS_PORT_C, 8'h05);
    rchk("b cleared", OFS_PORT_B, BYTE_ZERO);
    $display("test directions done");
    @(posedge ref_clk) {drv_a, drv_c, irq_enable_select_jumper} <= {8'h77, 8'h00, IRQ_SEL_LOW};
    wr(OFS_CONFIG, 8'hb1);
    wr(OFS_CONFIG, 8'h09);
    strobe(4'h1);
    chk("full flag", 8'h01, {7'h0, control_nibble_port_out[C_IBF_A]});
    chk("irq raised", 8'h01, {7'h0, irq});
    @(posedge ref_clk) drv_a <= 8'h11;
    rchk("a strobed", OFS_PORT_A, 8'h77);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("irq cleared", 8'h00, {7'h0, irq});
    wr(OFS_CONFIG, 8'h08);
    strobe(4'h8);
    chk("irq masked", 8'h00, {7'h0, irq});
    rchk("a slow", OFS_PORT_A, 8'h11);
    @(posedge ref_clk) irq_enable_select_jumper <= IRQ_SEL_NONE;
    wr(OFS_CONFIG, 8'h09);
    strobe(4'h2);
    chk("irq open", 8'h00, {7'h0, irq});
    $display("test handshake done");
    @(posedge ref_clk) {drv_b, drv_c, irq_enable_select_jumper} <= {8'h3e, 8'h04, IRQ_SEL_HIGH};
    wr(OFS_CONFIG, 8'h9f);
    wr(OFS_CONFIG, 8'h05);
    @(posedge ref_clk) drv_c <= 8'h00;
    @(posedge ref_clk) drv_c <= 8'h04;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("b full flag", 8'h01, {7'h0, control_nibble_port_out[C_FLAG_B]});
    chk("irq b", 8'h01, {7'h0, irq});
    rchk("b strobed", OFS_PORT_B, 8'h3e);
    $display("test group b done");
    @(posedge ref_clk) {drv_a, drv_c} <= {8'h4b, 8'h40};
    wr(OFS_CONFIG, 8'hc0);
    wr(OFS_PORT_A, 8'hc5);
    @(posedge ref_clk) drv_c <= 8'h00;
    #1;
    chk("obf low", 8'h00, {7'h0, control_nibble_port_out[C_OBF_A]});
    chk("a driven", 8'hc5, first_byte_port_in);
    @(posedge ref_clk) drv_c <= 8'h40;
    #1;
    chk("obf high", 8'h01, {7'h0, control_nibble_port_out[C_OBF_A]});
    strobe(4'h1);
    rchk("a bidir", OFS_PORT_A, 8'h4b);
    $display("test bidirectional done");
    end_of_test;
  end
endmodule
`default_nettype wire
